// ===== include/mcd_pkg.sv
package mcd_pkg;

  // Clock and machine-cycle timing
  localparam int MCD_CLK_PERIOD_NS = 10;
  localparam int MCD_STD_CLKS = 12;
  localparam int MCD_DBL_CLKS = 6;
  localparam int MCD_PHASE_W = 4;

  // APB geometry
  localparam int MCD_ADDR_W = 12;
  localparam int MCD_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] MCD_CTRL_IDX = 10'h001;
  localparam logic [9:0] MCD_MCYC_IDX = 10'h002;
  localparam logic [9:0] MCD_FSTAT_IDX = 10'h0B6;

  // Control register fields
  localparam int MCD_CTRL_CNT_EN_BIT = 0;
  localparam int MCD_CTRL_CLR_BIT = 1;
  localparam logic MCD_CTRL_CNT_EN_RST = 1'b0;

  // Flash status register fields and width
  localparam int MCD_FSTAT_W = 8;
  localparam int MCD_FSTAT_SIX_CLK_BIT = 3;
  localparam int MCD_FSTAT_ZERO_BIT = 2;

  // Machine-cycle mode, one-hot
  typedef enum logic [1:0] {
    MCD_MODE_STD = 2'b01,
    MCD_MODE_DBL = 2'b10
  } mcd_mode_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [MCD_ADDR_W-1:0] paddr;
    logic [MCD_DATA_W-1:0] pwdata;
  } mcd_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [MCD_DATA_W-1:0] prdata;
  } mcd_apb_rsp_t;

endpackage

// ===== rtl/mcd_phase_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module mcd_phase_cnt #(
  parameter int STD_CLKS = mcd_pkg::MCD_STD_CLKS,
  parameter int DBL_CLKS = mcd_pkg::MCD_DBL_CLKS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode in force for the running machine cycle
  input wire logic double_mode,
  // Machine-cycle position
  output logic [mcd_pkg::MCD_PHASE_W-1:0] phase,
  output logic mc_tick
);
  import mcd_pkg::*;

  typedef struct packed {
    logic [MCD_PHASE_W-1:0] phase;
  } mcd_pc_st_t;

  mcd_pc_st_t st_r;
  mcd_pc_st_t st_nxt;
  logic [MCD_PHASE_W-1:0] last_phase;

  // Refuse lengths the phase counter cannot hold
  if (DBL_CLKS < 1 || DBL_CLKS >= STD_CLKS || STD_CLKS > 16)
  begin : g_bad_len
    $error("mcd_phase_cnt: unsupported machine-cycle lengths");
  end

  // Last oscillator clock of the cycle for the selected mode
  assign last_phase = double_mode ? MCD_PHASE_W'(DBL_CLKS - 1)
                                  : MCD_PHASE_W'(STD_CLKS - 1);
  assign mc_tick = (st_r.phase == last_phase);
  assign phase = st_r.phase;

  // Phase advances on every oscillator clock and wraps at cycle end
  always_comb
  begin
    st_nxt = st_r;
    if (mc_tick)
    begin
      st_nxt.phase = '0;
    end
    else
    begin
      st_nxt.phase = st_r.phase + MCD_PHASE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_phase_bound: assert property (phase <= last_phase) // [R1]
    else $error("phase ran past the end of the machine cycle");

  a_phase_wrap: assert property (mc_tick |=> phase == '0) // [R2]
    else $error("phase did not wrap after cycle end");

endmodule
`default_nettype wire

// ===== rtl/mcd_top.sv
// Function
// R1: Out of reset and unless configured, a machine cycle is 12 clocks.
// R2: With double mode configured, a machine cycle is 6 clocks.
// R3: Only the programmer or in-application programming enables double mode.
// R4: Flash status bit 3 reads one while six-clock mode is active.
// R5: Doubling applies only while the external access pin is high.
// R6: Oscillator output pin carries the undoubled oscillator at all times.
// R7: Flash status has bit 2 zero after reset; no bit addressing.
// R8: Machine-cycle counters advance once per machine cycle of the mode.
`timescale 1ns/1ps
`default_nettype none
module mcd_top #(
  parameter int STD_CLKS = mcd_pkg::MCD_STD_CLKS,
  parameter int DBL_CLKS = mcd_pkg::MCD_DBL_CLKS
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire mcd_pkg::mcd_apb_req_t apb_req,
  output mcd_pkg::mcd_apb_rsp_t apb_rsp,
  // Oscillator pins
  input wire logic osc_in,
  output logic oscillator_output_pin,
  // Mode configuration sources
  input wire logic nv_double_strap,
  input wire logic prog_cfg_wr,
  input wire logic prog_cfg_double,
  input wire logic external_access_pin,
  // Machine-cycle outputs
  output logic machine_cycle_tick,
  output logic six_clock_mode_flag
);
  import mcd_pkg::*;

  typedef struct packed {
    logic cfg_loaded;
    logic cfg_double;
    mcd_mode_t mode;
    logic cnt_en;
    logic [MCD_DATA_W-1:0] mcyc;
    logic [MCD_DATA_W-1:0] rdata;
    logic rerr;
    logic [MCD_PHASE_W-1:0] gap;
  } mcd_top_st_t;

  mcd_top_st_t st_r;
  mcd_top_st_t st_nxt;
  logic mc_tick;
  logic [MCD_PHASE_W-1:0] mc_phase;
  logic setup;
  logic access;
  logic wr_en;
  logic [9:0] idx;
  logic dbl_req;
  logic clr_req;
  logic [MCD_FSTAT_W-1:0] fstat_val;

  // Machine-cycle sequencer
  mcd_phase_cnt #(
    .STD_CLKS(STD_CLKS),
    .DBL_CLKS(DBL_CLKS)
  ) i_mcd_phase_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .double_mode(st_r.mode == MCD_MODE_DBL),
    .phase(mc_phase),
    .mc_tick(mc_tick)
  );

  // Bus phase decode; byte address is index times four
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr_en = access && apb_req.pwrite;
  assign idx = apb_req.paddr[MCD_ADDR_W-1:2];
  assign clr_req = wr_en && (idx == MCD_CTRL_IDX)
                   && apb_req.pwdata[MCD_CTRL_CLR_BIT];

  // Doubling only runs from internal memory, so the pin gates it
  assign dbl_req = st_r.cfg_double && external_access_pin; // [R5]

  // Flash status image: only the mode flag is live, bit 2 held low
  always_comb
  begin
    fstat_val = '0; // [R7]
    fstat_val[MCD_FSTAT_SIX_CLK_BIT] = (st_r.mode == MCD_MODE_DBL); // [R4]
    fstat_val[MCD_FSTAT_ZERO_BIT] = 1'b0; // [R7]
  end

  // Whole-block next state
  always_comb
  begin
    st_nxt = st_r;
    // Strap is caught on the first edge after reset release, never in it
    if (!st_r.cfg_loaded)
    begin
      st_nxt.cfg_loaded = 1'b1;
      st_nxt.cfg_double = nv_double_strap; // [R3]
    end
    else if (prog_cfg_wr)
    begin
      st_nxt.cfg_double = prog_cfg_double; // [R3]
    end
    // Switch only on a cycle boundary so no cycle is cut short
    if (mc_tick)
    begin
      st_nxt.mode = dbl_req ? MCD_MODE_DBL : MCD_MODE_STD; // [R1] [R2]
    end
    // Clock gap helper, a separate count cleared on each sequencer tick
    st_nxt.gap = mc_tick ? '0 : st_r.gap + MCD_PHASE_W'(1);
    // Counter ticks once per machine cycle; a clear wins over a tick
    if (clr_req)
    begin
      st_nxt.mcyc = '0;
    end
    else if (st_r.cnt_en && mc_tick)
    begin
      st_nxt.mcyc = st_r.mcyc + 32'h0000_0001; // [R8]
    end
    if (wr_en && (idx == MCD_CTRL_IDX))
    begin
      st_nxt.cnt_en = apb_req.pwdata[MCD_CTRL_CNT_EN_BIT];
    end
    // Read data and error are prepared in the setup cycle
    if (setup)
    begin
      st_nxt.rdata = '0;
      st_nxt.rerr = 1'b0;
      if (idx == MCD_FSTAT_IDX)
      begin
        st_nxt.rdata[MCD_FSTAT_W-1:0] = fstat_val; // [R4]
        st_nxt.rerr = apb_req.pwrite; // [R3] read-only
      end
      else if (idx == MCD_CTRL_IDX)
      begin
        st_nxt.rdata[MCD_CTRL_CNT_EN_BIT] = st_r.cnt_en;
      end
      else if (idx == MCD_MCYC_IDX)
      begin
        st_nxt.rdata = st_r.mcyc;
        st_nxt.rerr = apb_req.pwrite;
      end
      else
      begin
        st_nxt.rerr = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r.cfg_loaded <= 1'b0;
      st_r.cfg_double <= 1'b0;
      st_r.mode <= MCD_MODE_STD; // [R1]
      st_r.cnt_en <= MCD_CTRL_CNT_EN_RST;
      st_r.mcyc <= 32'h0000_0000;
      st_r.rdata <= 32'h0000_0000;
      st_r.rerr <= 1'b0;
      st_r.gap <= 4'h0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Zero-wait answer in the access phase
  assign apb_rsp.pready = access;
  assign apb_rsp.pslverr = access && st_r.rerr;
  assign apb_rsp.prdata = st_r.rdata;

  // Crystal output is never doubled
  assign oscillator_output_pin = osc_in; // [R6]
  assign machine_cycle_tick = mc_tick; // [R8]
  assign six_clock_mode_flag = (st_r.mode == MCD_MODE_DBL); // [R4]

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_std_cycle_len: assert property ( // [R1]
    mc_tick && st_r.mode == MCD_MODE_STD
    |-> st_r.gap == MCD_PHASE_W'(STD_CLKS - 1))
    else $error("standard machine cycle is not 12 clocks");

  a_dbl_cycle_len: assert property ( // [R2]
    mc_tick && st_r.mode == MCD_MODE_DBL
    |-> st_r.gap == MCD_PHASE_W'(DBL_CLKS - 1))
    else $error("double machine cycle is not 6 clocks");

  a_reset_std: assert property ( // [R1]
    !st_r.cfg_loaded |-> st_r.mode == MCD_MODE_STD)
    else $error("mode left standard before configuration");

  a_no_bus_enable: assert property ( // [R3]
    st_r.cfg_loaded && !prog_cfg_wr |=> $stable(st_r.cfg_double))
    else $error("double configuration changed without a program write");

  a_flag_read: assert property ( // [R4]
    setup && !apb_req.pwrite && idx == MCD_FSTAT_IDX
    |=> apb_rsp.prdata[MCD_FSTAT_SIX_CLK_BIT]
      == $past(st_r.mode == MCD_MODE_DBL))
    else $error("flash status flag does not show the mode");

  a_ea_gate: assert property ( // [R5]
    mc_tick && !external_access_pin |=> st_r.mode == MCD_MODE_STD)
    else $error("doubling ran with external access low");

  a_osc_undoubled: assert property ( // [R6]
    st_r.mode == MCD_MODE_DBL |-> oscillator_output_pin == osc_in)
    else $error("oscillator output altered in double mode");

  a_fstat_bit2: assert property ( // [R7]
    setup && idx == MCD_FSTAT_IDX
    |=> apb_rsp.prdata[MCD_FSTAT_ZERO_BIT] == 1'b0)
    else $error("flash status bit 2 not zero");

  a_count_rate: assert property ( // [R8]
    st_r.cnt_en && !clr_req |=> st_r.mcyc == $past(st_r.mcyc)
      + ($past(mc_tick) ? 32'h0000_0001 : 32'h0000_0000))
    else $error("cycle counter not in step with machine cycles");

  c_dbl_tick: cover property (mc_tick && st_r.mode == MCD_MODE_DBL);
  c_std_tick: cover property (mc_tick && st_r.mode == MCD_MODE_STD);
  c_mode_switch: cover property (
    st_r.mode == MCD_MODE_STD ##1 st_r.mode == MCD_MODE_DBL);
  c_fstat_read: cover property (
    access && !apb_req.pwrite && idx == MCD_FSTAT_IDX);
  c_ea_hold: cover property (
    mc_tick && st_r.cfg_double && !external_access_pin);

endmodule
`default_nettype wire

// ===== sim/mcd_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcd_osc_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Oscillator level
  output logic osc
);
  // Flips every clock, so a stale copy is caught
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      osc <= 1'b0;
    else
      osc <= ~osc;
endmodule
`default_nettype wire

// ===== sim/mcd_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_clock_doubler_tb_top;
  import mcd_pkg::*;
  localparam logic [11:0] FSTAT = {MCD_FSTAT_IDX, 2'b00};
  localparam logic [11:0] CTL = {MCD_CTRL_IDX, 2'b00};
  localparam logic [11:0] MCY = {MCD_MCYC_IDX, 2'b00};
  logic pclk, presetn, osc, strap, iwr, idbl, ext_acc;
  logic opin, tick, flag, on, er;
  mcd_apb_req_t rq;
  mcd_apb_rsp_t rs;
  logic [31:0] rd;
  int err_total, n_tests, cyc, exp_n;

  mcd_osc_model i_mcd_osc_model (.pclk(pclk), .presetn(presetn),
    .osc(osc));
  mcd_top i_mcd_top (.pclk(pclk), .presetn(presetn), .apb_req(rq),
    .apb_rsp(rs), .osc_in(osc), .oscillator_output_pin(opin),
    .nv_double_strap(strap), .prog_cfg_wr(iwr), .prog_cfg_double(idbl),
    .external_access_pin(ext_acc), .machine_cycle_tick(tick),
    .six_clock_mode_flag(flag));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Watchdog, and a mirror of the tick counter while enabled
  always @(posedge pclk)
  begin
    cyc++;
    if (on && tick)
      exp_n++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Setup, then access held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    rq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    rq.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rs.pready !== 1'b1);
    rd = rs.prdata;
    er = rs.pslverr;
    rq <= '0;
  endtask

  // Clocks from one machine-cycle tick to the next
  task automatic gap(output int n);
    n = 0;
    while (tick !== 1'b1)
      @(posedge pclk) #1;
    do
    begin
      @(posedge pclk) #1;
      n++;
    end while (tick !== 1'b1 && n < 40);
  endtask

  task automatic rst(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Main sequence
  initial
  begin
    int n;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    exp_n = 0;
    rq = '0;
    {iwr, idbl, on, presetn, strap} = 5'h00;
    ext_acc = 1'b1;
    rst(1'b0);
    // Status after reset, refused writes and unmapped place
    apb(1'b0, FSTAT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, FSTAT, 32'h8);
    check({31'h0, er}, 32'h1);
    check({31'h0, flag}, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    check({31'h0, er}, 32'h1);
    gap(n);
    gap(n);
    check(32'(n), 32'd12);
    // Output pin follows the source every clock
    repeat (4)
    begin
      @(posedge pclk) #1;
      check({31'h0, opin}, {31'h0, osc});
    end
    // Clear and enable, count three cycles, compare
    apb(1'b1, CTL, 32'h3);
    on <= 1'b1;
    // Enable reads back set, the clear bit reads back zero
    apb(1'b0, CTL, 32'h0);
    check(rd, 32'h1);
    repeat (3) gap(n);
    apb(1'b1, CTL, 32'h0);
    on <= 1'b0;
    apb(1'b0, MCY, 32'h0);
    check(rd, 32'(exp_n));
    check(32'(exp_n >= 3), 32'h1);
    // Count is read-only: a write is refused and leaves it alone
    apb(1'b1, MCY, 32'h55);
    check({31'h0, er}, 32'h1);
    apb(1'b0, MCY, 32'h0);
    check(rd, 32'(exp_n));
    // In-application request for six-clock cycles
    @(posedge pclk);
    iwr <= 1'b1;
    idbl <= 1'b1;
    @(posedge pclk);
    iwr <= 1'b0;
    gap(n);
    gap(n);
    check(32'(n), 32'd6);
    apb(1'b0, FSTAT, 32'h0);
    check(rd, 32'h8);
    // External memory in use: no doubling
    ext_acc <= 1'b0;
    gap(n);
    gap(n);
    check(32'(n), 32'd12);
    check({31'h0, flag}, 32'h0);
    // Back onto the clock edge before touching pins again
    @(posedge pclk);
    ext_acc <= 1'b1;
    // Programmer strap seen across a mid-run reset
    rst(1'b1);
    gap(n);
    gap(n);
    check(32'(n), 32'd6);
    check({31'h0, flag}, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
